// ---- src/pcs_defs.vh ----
/*
 Shared constants for the configuration status and class block:
 dword decode, field positions, hardwired values and reset values.
 Assumes inclusion by bare name from design files that use it.
*/
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH

// ==========================================
// Configuration space layout
`define PCS_ADDR_CMD 8'h04
`define PCS_ADDR_STATUS 8'h06
`define PCS_ADDR_CLASS 8'h08
`define PCS_DW_CMD_STAT 6'h01
`define PCS_DW_CLASS 6'h02
`define PCS_DW_LSB 2
`define PCS_DW_MSB 7
`define PCS_STATUS_SHIFT 16

// ==========================================
// Command register bits held here
`define PCS_CMD_INT_DIS 10
`define PCS_CMD_SYSTEM_ERROR_DRIVER_ENABLE 8
`define PCS_CMD_PAR_EN 6
`define PCS_CMD_RESET 16'h0000

// ==========================================
// Status register bits
`define PCS_ST_PARITY_ERROR_DETECTED 15
`define PCS_ST_SYSTEM_ERROR_SIGNALED 14
`define PCS_ST_MASTER_ABORT_FLAG 13
`define PCS_ST_TARGET_ABORT_RECEIVED 12
`define PCS_ST_TARGET_ABORT_SIGNALED 11
`define PCS_ST_DEVSEL_HI 10
`define PCS_ST_DEVSEL_LO 9
`define PCS_ST_MDPAR 8
`define PCS_ST_FBB 7
`define PCS_ST_RSVD6 6
`define PCS_ST_HISPD 5
`define PCS_ST_CAPABILITY_LIST_PRESENT 4
`define PCS_ST_INT 3
`define PCS_ST_RESET 16'h0210
`define PCS_DEVSEL_MEDIUM 2'h1
`define PCS_HARD_ZERO 1'h0
`define PCS_HARD_ONE 1'h1

// ==========================================
// Class code fields
`define PCS_BASE_CATEGORY 8'h07
`define PCS_SUB_CATEGORY 8'h80
`define PCS_PROG_IF 8'h00

// ==========================================
// Byte lanes of a configuration dword
`define PCS_LANE0 0
`define PCS_LANE1 1
`define PCS_LANE2 2
`define PCS_LANE3 3

`endif

// ---- src/pcs_status_class.v ----
/*
 Command interrupt/error controls, status register and class code
 register of a target-only function, reached by configuration cycles.
 Assumes the bus interface decodes configuration cycles for this
 function and hands single-cycle read and write strobes on mclk.
*/
// Notes on behaviour
// [RULE_01] Writing one clears flag, zero keeps
// [RULE_02] Address or data parity sets bit 15
// [RULE_03] Signaled system error sets bit 14
// [RULE_04] Bits 13, 12, 8 read zero
// [RULE_05] Target abort termination sets bit 11
// [RULE_06] DEVSEL timing bits read 01b, medium
// [RULE_07] Back-to-back capable bit reads zero
// [RULE_08] High-speed capable bit reads zero
// [RULE_09] Capability list bit reads one
// [RULE_10] INTx driven when pending and not disabled
// [RULE_11] Interrupt disable leaves pending bit alone
// [RULE_12] Pending only for enabled valid conditions
// [RULE_13] Reserved status bits read zero
// [RULE_14] Base category reads 07h
// [RULE_15] Sub-category reads 80h
// [RULE_16] Programming interface reads zero
// [RULE_17] Low byte is silicon revision code
// [RULE_18] Interrupt disable bit resets zero, blocks INTx
// [RULE_19] Address parity SERR needs both enables
// [RULE_20] Read-only writes and reads cause nothing
`include "pcs_defs.vh"

module pcs_status_class #(
   parameter N_INT_SRC = 4,
   // Arbitrary neutral revision value
   parameter [7:0] SILICON_REVISION = 8'h5a
) (
   input wire mclk,
   input wire rst,
   input wire cfg_rd,
   input wire cfg_wr,
   input wire [7:0] cfg_addr,
   input wire [3:0] cfg_be,
   input wire [31:0] cfg_wdata,
   output reg [31:0] cfg_rdata_q,
   output reg cfg_ack_q,
   input wire addr_parity_err,
   input wire data_parity_err,
   input wire target_abort_done,
   input wire [N_INT_SRC-1:0] int_condition,
   input wire [N_INT_SRC-1:0] int_signal_en,
   output reg intx_oe_q,
   output reg serr_oe_q,
   output reg perr_oe_q,
   output reg [1:0] devsel_timing_q,
   output wire int_line_disable,
   output wire system_error_driver_enable,
   output wire parity_response_enable
);

   // ==========================================
   // Helper functions
   function lane_on;
      input [3:0] be;
      input integer lane;
      begin
         lane_on = be[lane];
      end
   endfunction

   function dw_hit;
      input [7:0] addr;
      input [5:0] dw;
      begin
         dw_hit = (addr[`PCS_DW_MSB:`PCS_DW_LSB] == dw);
      end
   endfunction

   // All clearable flags sit in the upper status byte
   function w1c_hit;
      input wr;
      input [3:0] be;
      input [31:0] wdata;
      input integer bitpos;
      begin
         w1c_hit = wr & be[`PCS_LANE3] & wdata[`PCS_STATUS_SHIFT + bitpos];
      end
   endfunction

   // ==========================================
   // Reset images, sliced per bit below
   localparam [15:0] CMD_RESET = `PCS_CMD_RESET;
   localparam [15:0] STATUS_RESET = `PCS_ST_RESET;

   // ==========================================
   // Declarations
   reg int_dis_q;
   reg int_dis_d;
   reg system_error_driver_enable_q;
   reg system_error_driver_enable_d;
   reg par_en_q;
   reg par_en_d;
   reg int_pending_q;
   reg int_pending_d;
   reg serr_pulse_q;
   reg [31:0] rdata_d;
   wire hit_cmd_stat;
   wire hit_class;
   wire wr_cmd_stat;
   wire wr_cmd_lo;
   wire wr_cmd_hi;
   wire rd_any;
   wire clr_parity_error_detected;
   wire clr_system_error_signaled;
   wire clr_target_abort_signaled;
   wire set_parity_error_detected;
   wire set_system_error_signaled;
   wire set_target_abort_signaled;
   wire parity_error_detected;
   wire system_error_signaled;
   wire target_abort_signaled;
   wire master_abort_flag;
   wire target_abort_received;
   wire master_data_parity_flag;
   wire back_to_back_capable;
   wire high_speed_capable;
   wire capability_list_present;
   wire [1:0] devsel_speed;
   wire [15:0] cmd_value;
   wire [15:0] status_value;
   wire [31:0] class_value;
   wire [7:0] base_category;
   wire [7:0] sub_category;
   wire [7:0] programming_interface_code;
   wire [7:0] silicon_revision;
   wire [N_INT_SRC-1:0] int_valid;
   wire serr_want;

   // ==========================================
   // Address decode
   assign hit_cmd_stat = dw_hit(cfg_addr, `PCS_DW_CMD_STAT);
   assign hit_class = dw_hit(cfg_addr, `PCS_DW_CLASS);
   // [RULE_20] Class dword never decoded for writes
   assign wr_cmd_stat = cfg_wr & hit_cmd_stat;
   assign wr_cmd_lo = wr_cmd_stat & lane_on(cfg_be, `PCS_LANE0);
   assign wr_cmd_hi = wr_cmd_stat & lane_on(cfg_be, `PCS_LANE1);
   assign rd_any = cfg_rd;

   // ==========================================
   // Command controls
   always @* begin
      int_dis_d = int_dis_q;
      system_error_driver_enable_d = system_error_driver_enable_q;
      par_en_d = par_en_q;
      if (wr_cmd_hi) begin
         int_dis_d = cfg_wdata[`PCS_CMD_INT_DIS];
         system_error_driver_enable_d = cfg_wdata[`PCS_CMD_SYSTEM_ERROR_DRIVER_ENABLE];
      end
      if (wr_cmd_lo) begin
         par_en_d = cfg_wdata[`PCS_CMD_PAR_EN];
      end
   end

   // [RULE_18] Disable bit resets to zero
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         int_dis_q <= CMD_RESET[`PCS_CMD_INT_DIS];
         system_error_driver_enable_q <= CMD_RESET[`PCS_CMD_SYSTEM_ERROR_DRIVER_ENABLE];
         par_en_q <= CMD_RESET[`PCS_CMD_PAR_EN];
      end else begin
         int_dis_q <= int_dis_d;
         system_error_driver_enable_q <= system_error_driver_enable_d;
         par_en_q <= par_en_d;
      end
   end

   assign int_line_disable = int_dis_q;
   assign system_error_driver_enable = system_error_driver_enable_q;
   assign parity_response_enable = par_en_q;

   assign cmd_value = {5'h00,
                       int_dis_q,
                       1'b0,
                       system_error_driver_enable_q,
                       1'b0,
                       par_en_q,
                       6'h00};

   // ==========================================
   // Error signaling
   // [RULE_19] SERR needs both enables
   assign serr_want = addr_parity_err & system_error_driver_enable_q & par_en_q;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         serr_pulse_q <= 1'b0;
         serr_oe_q <= 1'b0;
         perr_oe_q <= 1'b0;
      end else begin
         serr_pulse_q <= serr_want;
         serr_oe_q <= serr_want;
         perr_oe_q <= data_parity_err & par_en_q;
      end
   end

   // ==========================================
   // Clearable status flags
   // [RULE_01] One clears, zero keeps
   assign clr_parity_error_detected = w1c_hit(wr_cmd_stat, cfg_be, cfg_wdata, `PCS_ST_PARITY_ERROR_DETECTED);
   assign clr_system_error_signaled = w1c_hit(wr_cmd_stat, cfg_be, cfg_wdata, `PCS_ST_SYSTEM_ERROR_SIGNALED);
   assign clr_target_abort_signaled = w1c_hit(wr_cmd_stat, cfg_be, cfg_wdata, `PCS_ST_TARGET_ABORT_SIGNALED);

   // [RULE_02] Either parity error sets
   assign set_parity_error_detected = addr_parity_err | data_parity_err;
   // [RULE_03] Set when SERR was driven
   // Follows the pin pulse, so it lags bit 15 a cycle
   assign set_system_error_signaled = serr_pulse_q & system_error_driver_enable_q;
   // [RULE_05] Target abort termination sets
   assign set_target_abort_signaled = target_abort_done;

   pcs_sticky_flag u_parity_error_detected (
      .mclk(mclk),
      .rst(rst),
      .set_evt(set_parity_error_detected),
      .clr_req(clr_parity_error_detected),
      .flag_q(parity_error_detected)
   );

   pcs_sticky_flag u_system_error_signaled (
      .mclk(mclk),
      .rst(rst),
      .set_evt(set_system_error_signaled),
      .clr_req(clr_system_error_signaled),
      .flag_q(system_error_signaled)
   );

   pcs_sticky_flag u_target_abort_signaled (
      .mclk(mclk),
      .rst(rst),
      .set_evt(set_target_abort_signaled),
      .clr_req(clr_target_abort_signaled),
      .flag_q(target_abort_signaled)
   );

   // ==========================================
   // Interrupt pending and INTx
   genvar gi;
   generate
      for (gi = 0; gi < N_INT_SRC; gi = gi + 1) begin : g_int
         // [RULE_12] Only enabled conditions count
         assign int_valid[gi] = int_condition[gi] & int_signal_en[gi];
      end
   endgenerate

   // [RULE_11] Tracks sources, ignores disable and writes
   always @* begin
      int_pending_d = |int_valid;
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         int_pending_q <= STATUS_RESET[`PCS_ST_INT];
         intx_oe_q <= 1'b0;
      end else begin
         int_pending_q <= int_pending_d;
         // [RULE_10] Drive only pending and enabled
         // Next-state terms keep INTx in step with bit 3
         intx_oe_q <= int_pending_d & ~int_dis_d;
      end
   end

   // ==========================================
   // Hardwired status fields
   // [RULE_04] Target-only, master flags zero
   assign master_abort_flag = `PCS_HARD_ZERO;
   assign target_abort_received = `PCS_HARD_ZERO;
   assign master_data_parity_flag = `PCS_HARD_ZERO;
   // [RULE_06] Medium DEVSEL timing code
   assign devsel_speed = `PCS_DEVSEL_MEDIUM;
   // [RULE_07] No fast back-to-back
   assign back_to_back_capable = `PCS_HARD_ZERO;
   // [RULE_08] 33 MHz maximum
   assign high_speed_capable = `PCS_HARD_ZERO;
   // [RULE_09] Power-management list present
   assign capability_list_present = `PCS_HARD_ONE;

   // Medium timing is steered to the target state machine outside
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         devsel_timing_q <= `PCS_DEVSEL_MEDIUM;
      end else begin
         // [RULE_06] Advertised code drives decode timing
         devsel_timing_q <= devsel_speed;
      end
   end

   // [RULE_13] Reserved bits forced zero
   assign status_value = {parity_error_detected,
                          system_error_signaled,
                          master_abort_flag,
                          target_abort_received,
                          target_abort_signaled,
                          devsel_speed,
                          master_data_parity_flag,
                          back_to_back_capable,
                          1'b0,
                          high_speed_capable,
                          capability_list_present,
                          int_pending_q,
                          3'h0};

   // ==========================================
   // Class code and revision
   // [RULE_14] Communication device
   assign base_category = `PCS_BASE_CATEGORY;
   // [RULE_15] Other communication device
   assign sub_category = `PCS_SUB_CATEGORY;
   // [RULE_16] Interface code zero
   assign programming_interface_code = `PCS_PROG_IF;
   // [RULE_17] Revision from parameter
   assign silicon_revision = SILICON_REVISION;
   assign class_value = {base_category, sub_category,
                         programming_interface_code, silicon_revision};

   // ==========================================
   // Read path
   // [RULE_20] Reads only sample, never clear
   always @* begin
      rdata_d = 32'h00000000;
      if (rd_any && hit_cmd_stat) begin
         rdata_d = {status_value, cmd_value};
      end else if (rd_any && hit_class) begin
         rdata_d = class_value;
      end
   end

   // Unmapped dwords answer with zero data, still acknowledged
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         cfg_rdata_q <= 32'h00000000;
         cfg_ack_q <= 1'b0;
      end else begin
         cfg_ack_q <= cfg_rd | cfg_wr;
         if (rd_any) begin
            cfg_rdata_q <= rdata_d;
         end
      end
   end

endmodule // pcs_status_class

// ---- src/pcs_sticky_flag.v ----
/*
 One write-one-to-clear status flag set by a hardware event.
 Assumes set and clear arrive as one-cycle pulses on mclk.
*/
module pcs_sticky_flag (
   input wire mclk,
   input wire rst,
   input wire set_evt,
   input wire clr_req,
   output reg flag_q
);
   reg flag_d;

   // ==========================================
   // Set wins over a clear in the same cycle
   always @* begin
      flag_d = flag_q;
      if (clr_req) begin
         flag_d = 1'b0;
      end
      if (set_evt) begin
         flag_d = 1'b1;
      end
   end

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end
endmodule // pcs_sticky_flag

// ---- testbench/pcs_host_model.sv ----
/*
 Host bridge model issuing single configuration cycles.
 Assumes ack and read data just after the taking edge.
*/
module pcs_host_model (
   input wire mclk,
   output logic cfg_rd,
   output logic cfg_wr,
   output logic [7:0] cfg_addr,
   output logic [3:0] cfg_be,
   output logic [31:0] cfg_wdata,
   input wire [31:0] cfg_rdata_q,
   input wire cfg_ack_q
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {cfg_rd, cfg_wr, cfg_be, cfg_addr, cfg_wdata} = 46'h0;
   end
   // ========
   // One access
   task automatic access(input logic wr, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q, output logic ack);
      @(posedge mclk);
      #1;
      {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {!wr, wr, a, be, d};
      @(posedge mclk);
      #1;
      ack = cfg_ack_q;
      q = cfg_rdata_q;
      // Released strobes drop and other lines invert, so stale values never look valid
      {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {2'h0, ~a, ~be, ~d};
   endtask
endmodule // pcs_host_model

// ---- testbench/pcs_status_class_asserts.sv ----
/*
 Port assertions for the status and class block.
 Assumes a bind onto pcs_status_class with its parameters.
*/
module pcs_status_class_asserts #(
   parameter N_INT_SRC = 4,
   parameter [7:0] SILICON_REVISION = 8'h5a
) (
   input wire mclk,
   input wire rst,
   input wire cfg_rd,
   input wire cfg_wr,
   input wire [7:0] cfg_addr,
   input wire [31:0] cfg_rdata_q,
   input wire cfg_ack_q,
   input wire addr_parity_err,
   input wire data_parity_err,
   input wire [N_INT_SRC-1:0] int_condition,
   input wire [N_INT_SRC-1:0] int_signal_en,
   input wire intx_oe_q,
   input wire serr_oe_q,
   input wire perr_oe_q,
   input wire [1:0] devsel_timing_q,
   input wire int_line_disable,
   input wire system_error_driver_enable,
   input wire parity_response_enable
);
   timeunit 1ns;
   timeprecision 1ns;
   // ========
   // Checks
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_intx_gate: assert property (
      intx_oe_q == ($past(|(int_condition & int_signal_en)) && !int_line_disable))
      else $error("intx wrong");
   a_serr_both_en: assert property (
      serr_oe_q == $past(addr_parity_err && system_error_driver_enable
      && parity_response_enable)) else $error("serr pulse wrong");
   a_parity_response_enable: assert property (
      perr_oe_q == $past(data_parity_err && parity_response_enable))
      else $error("perr pulse wrong");
   a_devsel_medium: assert property (
      devsel_timing_q == 2'h1) else $error("devsel not medium");
   a_status_fixed: assert property (
      cfg_ack_q && $past(cfg_rd && cfg_addr[7:2] == 6'h01)
      |-> (cfg_rdata_q[31:16] & 16'h37f7) == 16'h0210) else $error("status fixed bits");
   a_fbb_zero: assert property (
      cfg_ack_q && $past(cfg_rd && cfg_addr[7:2] == 6'h01)
      |-> !cfg_rdata_q[23]) else $error("back to back bit set");
   a_hispd_zero: assert property (
      cfg_ack_q && $past(cfg_rd && cfg_addr[7:2] == 6'h01)
      |-> !cfg_rdata_q[21]) else $error("high speed bit set");
   a_class_const: assert property (
      cfg_ack_q && $past(cfg_rd && cfg_addr[7:2] == 6'h02)
      |-> cfg_rdata_q == {24'h078000, SILICON_REVISION}) else $error("class wrong");
   a_rev_byte: assert property (
      cfg_ack_q && $past(cfg_rd && cfg_addr[7:2] == 6'h02)
      |-> cfg_rdata_q[7:0] == SILICON_REVISION) else $error("revision wrong");
   a_ctrl_by_write: assert property (
      $changed({int_line_disable, system_error_driver_enable, parity_response_enable})
      |-> $past(cfg_wr && cfg_addr[7:2] == 6'h01)) else $error("command moved");
   a_rdata_hold: assert property (
      !$past(cfg_rd) |-> $stable(cfg_rdata_q)) else $error("read data moved");
endmodule // pcs_status_class_asserts

// ---- testbench/pcs_status_class_test.sv ----
/*
 Self-checking bench for the status and class block.
 Assumes the host model and checker files compile first.
*/
bind pcs_status_class pcs_status_class_asserts #(.N_INT_SRC(N_INT_SRC),
   .SILICON_REVISION(SILICON_REVISION)) u_chk (.mclk, .rst, .cfg_rd, .cfg_wr, .cfg_addr,
   .cfg_rdata_q, .cfg_ack_q, .addr_parity_err, .data_parity_err, .int_condition,
   .int_signal_en, .intx_oe_q, .serr_oe_q, .perr_oe_q, .devsel_timing_q, .int_line_disable,
   .system_error_driver_enable, .parity_response_enable);

module pcs_status_class_test;
   timeunit 1ns;
   timeprecision 1ns;
   // Arbitrary revision value
   localparam [7:0] REV = 8'h3c;
   logic mclk;
   logic rst;
   logic [2:0] evt;
   logic [3:0] icond;
   logic [3:0] ien;
   wire cfg_rd;
   wire cfg_wr;
   wire [7:0] cfg_addr;
   wire [3:0] cfg_be;
   wire [31:0] cfg_wdata;
   wire [31:0] cfg_rdata_q;
   wire cfg_ack_q;
   wire intx_oe_q;
   int error_cnt = 0;
   int checked = 0;

   pcs_status_class #(.N_INT_SRC(4), .SILICON_REVISION(REV)) DUT (
      .mclk, .rst, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata_q,
      .cfg_ack_q, .addr_parity_err(evt[2]), .data_parity_err(evt[1]),
      .target_abort_done(evt[0]), .int_condition(icond), .int_signal_en(ien),
      .intx_oe_q, .serr_oe_q(), .perr_oe_q(), .devsel_timing_q(), .int_line_disable(),
      .system_error_driver_enable(), .parity_response_enable());
   pcs_host_model host (.mclk, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
      .cfg_rdata_q, .cfg_ack_q);

   // ========
   // Helpers
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d, input logic [31:0] exp, input string what);
      logic [31:0] q;
      logic ack;
      host.access(w, a, be, d, q, ack);
      check("ack", {31'h0, ack}, 32'h1);
      if (!w) begin
         check(what, q, exp);
      end
   endtask
   task automatic fire(input logic [2:0] which);
      @(posedge mclk);
      #1;
      evt = which;
      @(posedge mclk);
      #1;
      evt = 3'h0;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ========
   // Scenarios
   task automatic t_ident;
      acc(1'b0, 8'h04, 4'hf, 0, 32'h0210_0000, "reset status");
      acc(1'b0, 8'h08, 4'hf, 0, {24'h078000, REV}, "class");
      acc(1'b1, 8'h08, 4'hf, 32'hffff_ffff, 0, "");
      acc(1'b1, 8'h04, 4'hc, 32'hffff_0000, 0, "");
      acc(1'b0, 8'h08, 4'hf, 0, {24'h078000, REV}, "class kept");
      acc(1'b0, 8'h08, 4'hf, 0, {24'h078000, REV}, "revision");
      acc(1'b0, 8'h04, 4'hf, 0, 32'h0210_0000, "status kept");
      acc(1'b0, 8'h10, 4'hf, 0, 32'h0, "unmapped");
   endtask
   task automatic t_parity;
      fire(3'h4);
      acc(1'b0, 8'h04, 4'hf, 0, 32'h8210_0000, "parity no serr");
      acc(1'b1, 8'h04, 4'hc, 32'h0, 0, "");
      acc(1'b0, 8'h04, 4'hf, 0, 32'h8210_0000, "zero kept");
      acc(1'b1, 8'h04, 4'h4, 32'hffff_ffff, 0, "");
      acc(1'b0, 8'h04, 4'hf, 0, 32'h8210_0000, "lane kept");
      acc(1'b1, 8'h04, 4'hc, 32'h8000_0000, 0, "");
      acc(1'b0, 8'h04, 4'hf, 0, 32'h0210_0000, "one clears");
      acc(1'b1, 8'h04, 4'h3, 32'h0000_0100, 0, "");
      fire(3'h4);
      acc(1'b0, 8'h04, 4'hf, 0, 32'h8210_0100, "serr half on");
      acc(1'b1, 8'h04, 4'hf, 32'h8000_0140, 0, "");
      fire(3'h4);
      acc(1'b0, 8'h04, 4'hf, 0, 32'hc210_0140, "serr flag");
      acc(1'b1, 8'h04, 4'hc, 32'hc000_0000, 0, "");
      fire(3'h2);
      acc(1'b0, 8'h04, 4'hf, 0, 32'h8210_0140, "data parity");
      fire(3'h1);
      acc(1'b0, 8'h04, 4'hf, 0, 32'h8a10_0140, "abort flag");
      acc(1'b1, 8'h04, 4'hf, 32'h8800_0000, 0, "");
      acc(1'b0, 8'h04, 4'hf, 0, 32'h0210_0000, "cleared");
   endtask
   task automatic t_int;
      icond = 4'h2;
      ien = 4'hd;
      acc(1'b0, 8'h04, 4'hf, 0, 32'h0210_0000, "masked");
      check("intx masked", {31'h0, intx_oe_q}, 32'h0);
      ien = 4'h2;
      acc(1'b0, 8'h04, 4'hf, 0, 32'h0218_0000, "pending");
      check("intx on", {31'h0, intx_oe_q}, 32'h1);
      acc(1'b1, 8'h04, 4'hf, 32'h0008_0400, 0, "");
      acc(1'b0, 8'h04, 4'hf, 0, 32'h0218_0400, "disabled");
      check("intx off", {31'h0, intx_oe_q}, 32'h0);
      icond = 4'h0;
      acc(1'b0, 8'h04, 4'hf, 0, 32'h0210_0400, "gone");
      fire(3'h4);
      rst = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      rst = 1'b0;
      acc(1'b0, 8'h04, 4'hf, 0, 32'h0210_0000, "rerun");
   endtask

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // Whole run is about 80 cycles, limit is 800
   initial begin
      #40000;
      error_cnt++;
      stop_test;
   end
   initial begin
      rst = 1'b1;
      evt = 3'h0;
      icond = 4'h0;
      ien = 4'h0;
      repeat (3) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_ident;
      t_parity;
      t_int;
      stop_test;
   end
endmodule // pcs_status_class_test
